// >>> hw/twmoc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Waveform mode decode and compare output control
module twmoc_top
  import twmoc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [1:0]  regAddr,      // Register index
  input  wire logic [7:0]  regWdata,     // Write data
  input  wire logic        regWrite,     // Write strobe
  input  wire logic        regRead,      // Read strobe
  output logic [7:0]       regRdata,     // Read data, next cycle
  input  wire logic        tick,         // Timer clock enable
  input  wire logic [15:0] countValue,   // Counter value
  input  wire logic        countDown,    // Count direction
  input  wire logic        matchA,       // Channel A compare match
  input  wire logic        matchB,       // Channel B compare match
  input  wire logic [15:0] cmpA,         // Active compare A
  input  wire logic [15:0] cmpB,         // Active compare B
  input  wire logic [15:0] captureValue, // Capture register
  input  wire logic [3:0]  portDirA,     // Direction bits, A pins
  input  wire logic [3:0]  portDirB,     // Direction bits, B pins
  input  wire logic [3:0]  portDataA,    // Port data, A pins
  input  wire logic [3:0]  portDataB,    // Port data, B pins
  output logic [15:0]      ceiling,      // Decoded ceiling value
  output logic [1:0]       ceilSource,   // Ceiling source
  output logic [1:0]       updatePoint,  // Buffer update point
  output logic [1:0]       overflowPoint,// Overflow flag point
  output logic             dualSlope,    // Up then down counting
  output logic             overflowFlag, // Overflow event pulse
  output logic             chanAWaveOut, // Channel A wave
  output logic             chanBWaveOut, // Channel B wave
  output logic [3:0]       pinOutA,      // A pin values
  output logic [3:0]       pinOeA,       // A pin enables
  output logic [3:0]       pinOutB,      // B pin values
  output logic [3:0]       pinOeB        // B pin enables
);
  logic [7:0] timerWaveControlA;   // Control register A
  logic [7:0] timerClockControlB;  // Mode high bits only
  logic [7:0] timerPinEnableReg;   // Pin enables
  logic [3:0] waveformModeCode;    // Combined mode
  twmoc_fam_t family;              // Decoded family
  twmoc_ceil_src_t next_src;       // Decoded ceiling source
  twmoc_upd_t next_upd;            // Decoded update point
  twmoc_ovf_t next_ovf;            // Decoded overflow point
  logic [15:0] next_ceiling;       // Decoded ceiling
  logic next_ovfEvent;             // Overflow condition now
  logic atTop;                     // Count at ceiling

  // Combined mode code from both registers
  assign waveformModeCode = {timerClockControlB[MODE_HIGH_HI:MODE_HIGH_LO],
                             timerWaveControlA[MODE_LOW_HI:0]};

  // Mask a write to the implemented bits
  function automatic logic [7:0] maskWrite(input logic [7:0] d, input logic [7:0] m);
    maskWrite = d & m;
  endfunction : maskWrite

  // Control registers; reserved bits never stored
  always_ff @(posedge clock) begin
    if (rst) begin
      timerWaveControlA  <= CTRL_RESET;
      timerClockControlB <= CTRL_RESET;
      timerPinEnableReg  <= CTRL_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        ADDR_CTRL_A: timerWaveControlA  <= maskWrite(regWdata, CTRL_A_MASK);
        ADDR_CTRL_B: timerClockControlB <= maskWrite(regWdata, CTRL_B_MASK);
        ADDR_PIN_EN: timerPinEnableReg  <= regWdata;
        ADDR_STATUS: timerPinEnableReg  <= timerPinEnableReg;
      endcase
    end
  end

  // Read port; status shows waves and direction
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_CTRL_A: regRdata <= timerWaveControlA;
        ADDR_CTRL_B: regRdata <= timerClockControlB;
        ADDR_PIN_EN: regRdata <= timerPinEnableReg;
        ADDR_STATUS: regRdata <= {5'h00, countDown, chanBWaveOut, chanAWaveOut};
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Mode table decode; reserved code falls back to normal
  always_comb begin
    family = TWMOC_FAM_PLAIN;
    next_src = TWMOC_CEIL_FIXED;
    next_upd = TWMOC_UPD_NOW;
    next_ovf = TWMOC_OVF_MAX;
    next_ceiling = CEIL_MAX;
    unique case (waveformModeCode)
      4'h0: next_ceiling = CEIL_MAX;
      4'h4: begin
        next_src = TWMOC_CEIL_CMPA;
        next_ceiling = cmpA;
      end
      4'hC: begin
        next_src = TWMOC_CEIL_CAPTURE;
        next_ceiling = captureValue;
      end
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin
        family = TWMOC_FAM_DUAL;
        next_upd = TWMOC_UPD_TOP;
        next_ovf = TWMOC_OVF_FLOOR;
        unique case (waveformModeCode)
          4'h1: next_ceiling = CEIL_8;
          4'h2: next_ceiling = CEIL_9;
          4'h3: next_ceiling = CEIL_10;
          4'hA: begin
            next_src = TWMOC_CEIL_CAPTURE;
            next_ceiling = captureValue;
          end
          default: begin
            next_src = TWMOC_CEIL_CMPA;
            next_ceiling = cmpA;
          end
        endcase
      end
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
        family = TWMOC_FAM_FAST;
        next_upd = TWMOC_UPD_TOP;
        next_ovf = TWMOC_OVF_TOP;
        unique case (waveformModeCode)
          4'h5: next_ceiling = CEIL_8;
          4'h6: next_ceiling = CEIL_9;
          4'h7: next_ceiling = CEIL_10;
          4'hE: begin
            next_src = TWMOC_CEIL_CAPTURE;
            next_ceiling = captureValue;
          end
          default: begin
            next_src = TWMOC_CEIL_CMPA;
            next_ceiling = cmpA;
          end
        endcase
      end
      4'h8, 4'h9: begin
        family = TWMOC_FAM_DUAL;
        next_upd = TWMOC_UPD_FLOOR;
        next_ovf = TWMOC_OVF_FLOOR;
        if (waveformModeCode == 4'h8) begin
          next_src = TWMOC_CEIL_CAPTURE;
          next_ceiling = captureValue;
        end else begin
          next_src = TWMOC_CEIL_CMPA;
          next_ceiling = cmpA;
        end
      end
      MODE_RESERVED: next_ceiling = CEIL_MAX;
    endcase
  end

  assign atTop = (countValue == next_ceiling);

  // Overflow condition per selected point
  always_comb begin
    unique case (next_ovf)
      TWMOC_OVF_MAX:   next_ovfEvent = (countValue == CEIL_MAX);
      TWMOC_OVF_TOP:   next_ovfEvent = atTop;
      TWMOC_OVF_FLOOR: next_ovfEvent = (countValue == COUNT_FLOOR);
      default:         next_ovfEvent = 1'b0;
    endcase
  end

  // Decoded info to the counter, registered
  always_ff @(posedge clock) begin
    if (rst) begin
      ceiling       <= CEIL_MAX;
      ceilSource    <= TWMOC_CEIL_FIXED;
      updatePoint   <= TWMOC_UPD_NOW;
      overflowPoint <= TWMOC_OVF_MAX;
      dualSlope     <= 1'b0;
    end else begin
      ceiling       <= next_ceiling;
      ceilSource    <= next_src;
      updatePoint   <= next_upd;
      overflowPoint <= next_ovf;
      dualSlope     <= (family == TWMOC_FAM_DUAL);
    end
  end

  // Overflow pulse on a tick at the selected point
  always_ff @(posedge clock) begin
    if (rst) begin
      overflowFlag <= 1'b0;
    end else begin
      overflowFlag <= tick && next_ovfEvent;
    end
  end

  // Channel A output stage
  twmoc_wave_chan u_chan_a (
    .clock     (clock),
    .rst       (rst),
    .tick      (tick),
    .action    (timerWaveControlA[CHA_ACT_HI:CHA_ACT_LO]),
    .family    (family),
    .modeTop   (waveformModeCode[3]),
    .isChanA   (1'b1),
    .match     (matchA),
    .atTop     (atTop),
    .countDown (countDown),
    .cmpIsTop  (cmpA == next_ceiling),
    .pinEnable (timerPinEnableReg[3:0]),
    .portDir   (portDirA),
    .portData  (portDataA),
    .waveOut   (chanAWaveOut),
    .pinOut    (pinOutA),
    .pinOe     (pinOeA)
  );

  // Channel B output stage
  twmoc_wave_chan u_chan_b (
    .clock     (clock),
    .rst       (rst),
    .tick      (tick),
    .action    (timerWaveControlA[CHB_ACT_HI:CHB_ACT_LO]),
    .family    (family),
    .modeTop   (waveformModeCode[3]),
    .isChanA   (1'b0),
    .match     (matchB),
    .atTop     (atTop),
    .countDown (countDown),
    .cmpIsTop  (cmpB == next_ceiling),
    .pinEnable (timerPinEnableReg[7:4]),
    .portDir   (portDirB),
    .portData  (portDataB),
    .waveOut   (chanBWaveOut),
    .pinOut    (pinOutB),
    .pinOe     (pinOeB)
  );
endmodule : twmoc_top
`default_nettype wire

// >>> hw/twmoc_pkg.sv
// Overview of operation
// - Nonzero action field routes wave to pin, except PWM code 01 when off
// - Pin driven on direction bit; wave also needs enable
// - Non-PWM codes: off, toggle, clear, set
// - PWM code 01: off, or A toggles
// - Fast PWM 10/11 clear/set, inverse at ceiling
// - Fast PWM 10/11 ignore match equal to ceiling
// - Dual-slope 10/11 depend on count direction
// - Four-bit mode split; code 13 reserved
// - Mode 0 ceiling FFFF, immediate, flag at max
// - Modes 4, 12 ceiling A or capture
// - Phase-correct modes update top, flag floor
// - Fast PWM modes update and flag at top
// - Modes 8, 9 update and flag at floor
// - Bits 3:2 read zero; reset zero
// - Dual slope counts up then down
// - Upper mode bits at register B 4:3
package twmoc_pkg;
  // Register indices on the local port
  localparam logic [1:0] ADDR_CTRL_A  = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B  = 2'h1;
  localparam logic [1:0] ADDR_PIN_EN  = 2'h2;
  localparam logic [1:0] ADDR_STATUS  = 2'h3;
  // Field positions
  localparam int CHA_ACT_HI  = 7;
  localparam int CHA_ACT_LO  = 6;
  localparam int CHB_ACT_HI  = 5;
  localparam int CHB_ACT_LO  = 4;
  localparam int MODE_LOW_HI = 1;
  localparam int MODE_HIGH_HI = 4;
  localparam int MODE_HIGH_LO = 3;
  // Writable masks and reset values
  localparam logic [7:0] CTRL_A_MASK  = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK  = 8'h18;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  // Ceilings
  localparam logic [15:0] CEIL_MAX = 16'hFFFF;
  localparam logic [15:0] CEIL_8   = 16'h00FF;
  localparam logic [15:0] CEIL_9   = 16'h01FF;
  localparam logic [15:0] CEIL_10  = 16'h03FF;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  // Ceiling source select
  typedef enum logic [1:0] {
    TWMOC_CEIL_FIXED   = 2'h0,
    TWMOC_CEIL_CMPA    = 2'h1,
    TWMOC_CEIL_CAPTURE = 2'h2
  } twmoc_ceil_src_t;
  // Compare buffer update point
  typedef enum logic [1:0] {
    TWMOC_UPD_NOW   = 2'h0,
    TWMOC_UPD_TOP   = 2'h1,
    TWMOC_UPD_FLOOR = 2'h2
  } twmoc_upd_t;
  // Overflow flag point
  typedef enum logic [1:0] {
    TWMOC_OVF_MAX   = 2'h0,
    TWMOC_OVF_TOP   = 2'h1,
    TWMOC_OVF_FLOOR = 2'h2
  } twmoc_ovf_t;
  // Mode families
  typedef enum logic [1:0] {
    TWMOC_FAM_PLAIN = 2'h0,
    TWMOC_FAM_FAST  = 2'h1,
    TWMOC_FAM_DUAL  = 2'h3
  } twmoc_fam_t;
endpackage : twmoc_pkg

// >>> hw/twmoc_wave_chan.sv
`timescale 1ns/1ps
`default_nettype none
// One waveform output flop and its pin routing
module twmoc_wave_chan
  import twmoc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       tick,        // Timer clock enable
  input  wire logic [1:0] action,      // Output action field
  input  wire twmoc_fam_t family,      // Mode family
  input  wire logic       modeTop,     // Upper mode bit
  input  wire logic       isChanA,     // Channel A may toggle in PWM
  input  wire logic       match,       // Compare match from counter
  input  wire logic       atTop,       // Count at ceiling
  input  wire logic       countDown,   // Counting downward
  input  wire logic       cmpIsTop,    // Compare equals ceiling
  input  wire logic [3:0] pinEnable,   // Per-pin output enables
  input  wire logic [3:0] portDir,     // Port direction bits
  input  wire logic [3:0] portData,    // Ordinary port outputs
  output logic            waveOut,     // Waveform flop
  output logic [3:0]      pinOut,      // Pin output value
  output logic [3:0]      pinOe        // Pin driver enable
);
  logic next_wave;  // Next waveform value
  logic connected;  // Wave takes over pin

  // Connection decision per action code and family
  always_comb begin
    connected = (action != 2'b00);
    if (action == 2'b01 && family != TWMOC_FAM_PLAIN) begin
      connected = modeTop && isChanA;
    end
  end

  // Event decode; B toggle in PWM is reserved so stays off
  always_comb begin
    next_wave = waveOut;
    unique case (family)
      TWMOC_FAM_PLAIN: begin
        if (match) begin
          unique case (action)
            2'b00: next_wave = waveOut;
            2'b01: next_wave = ~waveOut;
            2'b10: next_wave = 1'b0;
            2'b11: next_wave = 1'b1;
          endcase
        end
      end
      TWMOC_FAM_FAST: begin
        if (action == 2'b01) begin
          if (match && connected) next_wave = ~waveOut;
        end else if (action[1]) begin
          // Match at ceiling ignored, ceiling action still done
          if (match && !cmpIsTop) next_wave = ~action[0] ? 1'b0 : 1'b1;
          if (atTop) next_wave = action[0] ? 1'b0 : 1'b1;
        end
      end
      TWMOC_FAM_DUAL: begin
        if (action == 2'b01) begin
          if (match && connected) next_wave = ~waveOut;
        end else if (action[1] && match) begin
          next_wave = (countDown ^ action[0]);
        end
      end
      default: next_wave = waveOut;
    endcase
  end

  // Wave flop, updated on ticks only
  always_ff @(posedge clock) begin
    if (rst) begin
      waveOut <= 1'b0;
    end else if (tick) begin
      waveOut <= next_wave;
    end
  end

  // Pin routing registered so outputs come from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      pinOut <= 4'h0;
      pinOe  <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pinOe[i]  <= portDir[i];
        // Without a tick the flop holds, so the pin must show the held value
        pinOut[i] <= (connected && pinEnable[i]) ? (tick ? next_wave : waveOut)
                                                 : portData[i];
      end
    end
  end
endmodule : twmoc_wave_chan
`default_nettype wire

// >>> tb/twmoc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level timing checks for the wave control block
module twmoc_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [1:0]  regAddr,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic        tick,
  input wire logic [15:0] countValue,
  input wire logic [15:0] ceiling,
  input wire logic [1:0]  ceilSource,
  input wire logic [1:0]  updatePoint,
  input wire logic [1:0]  overflowPoint,
  input wire logic        dualSlope,
  input wire logic        overflowFlag,
  input wire logic        chanAWaveOut,
  input wire logic        chanBWaveOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Reads of the two control registers
  sequence s_rd_a; regRead && regAddr == 2'h0; endsequence
  sequence s_rd_b; regRead && regAddr == 2'h1; endsequence
  chk_rd_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not idle");
  chk_rsv_zero: assert property (s_rd_a |=> regRdata[3:2] == 2'b00)
    else $error("reserved bits not zero");
  chk_ctlb_bits: assert property (s_rd_b |=> (regRdata & 8'hE7) == 8'h00)
    else $error("control B stray bits");
  // Flops move only on timer enable cycles; decoded outputs agree with each other
  chk_wave_idle: assert property (!tick |=> $stable(chanAWaveOut) && $stable(chanBWaveOut))
    else $error("wave moved without tick");
  chk_ovf_tick: assert property (overflowFlag |-> $past(tick))
    else $error("overflow without tick");
  chk_fixed_ceil: assert property (ceilSource == 2'h0 |->
    ceiling inside {16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF})
    else $error("fixed ceiling wrong");
  chk_upd_now: assert property (updatePoint == 2'h0 |-> overflowPoint == 2'h0 && !dualSlope)
    else $error("immediate mode decode wrong");
  chk_floor_dual: assert property ((overflowPoint == 2'h2) == dualSlope)
    else $error("floor flag and slope differ");
  // Overflow pulse tied to the count that caused it
  chk_ovf_max: assert property (overflowFlag && $past(overflowPoint) == 2'h0 |->
    $past(countValue) == 16'hFFFF)
    else $error("overflow not at max");
  chk_ovf_top: assert property (overflowFlag && $past(overflowPoint) == 2'h1 |->
    $past(countValue) == $past(ceiling))
    else $error("overflow not at ceiling");
  chk_ovf_floor: assert property (overflowFlag && $past(overflowPoint) == 2'h2 |->
    $past(countValue) == 16'h0000)
    else $error("overflow not at floor");
endmodule : twmoc_checker
bind twmoc_top twmoc_checker u_twmoc_checker (.clock, .rst, .regAddr, .regRead, .regRdata,
  .tick, .countValue, .ceiling, .ceilSource, .updatePoint, .overflowPoint, .dualSlope,
  .overflowFlag, .chanAWaveOut, .chanBWaveOut);
`default_nettype wire

// >>> tb/twmoc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench with an integer model of decode and wave flops
module twmoc_top_tb;
  import twmoc_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  regAddr = 2'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0, regRead = 1'b0, tick = 1'b0;
  logic [15:0] countValue = 16'h0000;
  logic        countDown = 1'b0, matchA = 1'b0, matchB = 1'b0;
  logic [15:0] cmpA = 16'h0100, cmpB = 16'h0200, captureValue = 16'h0300;
  logic [3:0]  portDirA = 4'h0, portDirB = 4'h0, portDataA = 4'h0, portDataB = 4'h0;
  logic [7:0]  regRdata;
  logic [15:0] ceiling;
  logic [1:0]  ceilSource, updatePoint, overflowPoint;
  logic        dualSlope, overflowFlag, chanAWaveOut, chanBWaveOut;
  logic [3:0]  pinOutA, pinOeA, pinOutB, pinOeB;
  logic [31:0] rnd = 32'h35B2F7BF;  // Stimulus state
  int          checks = 0, err_total = 0;
  int          mode = 0, actA = 0, actB = 0;  // Model copy of control
  logic        wA = 1'b0, wB = 1'b0;  // Model wave flops
  logic [7:0]  pinEn = 8'h00;  // Model pin enables
  logic [7:0]  expQ[$];  // Expected read data, in issue order
  // Free running clock
  always #12.5 clock = ~clock;
  twmoc_top u_twmoc_top (.clock, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .tick, .countValue, .countDown, .matchA, .matchB, .cmpA, .cmpB, .captureValue,
    .portDirA, .portDirB, .portDataA, .portDataB, .ceiling, .ceilSource, .updatePoint,
    .overflowPoint, .dualSlope, .overflowFlag, .chanAWaveOut, .chanBWaveOut,
    .pinOutA, .pinOeA, .pinOutB, .pinOeB);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Mode tables kept as plain lookups
  function automatic logic [15:0] ceilOf(input int m);
    case (m)
      1, 5: return 16'h00FF;
      2, 6: return 16'h01FF;
      3, 7: return 16'h03FF;
      4, 9, 11, 15: return cmpA;
      8, 10, 12, 14: return captureValue;
      default: return 16'hFFFF;
    endcase
  endfunction : ceilOf
  function automatic int srcOf(input int m);
    return (m inside {4, 9, 11, 15}) ? 1 : (m inside {8, 10, 12, 14}) ? 2 : 0;
  endfunction : srcOf
  function automatic int updOf(input int m);
    return (m inside {0, 4, 12, 13}) ? 0 : (m inside {8, 9}) ? 2 : 1;
  endfunction : updOf
  function automatic int ovfOf(input int m);
    return (m inside {0, 4, 12, 13}) ? 0 : (m inside {5, 6, 7, 14, 15}) ? 1 : 2;
  endfunction : ovfOf
  // Next wave value for one channel on a tick
  function automatic logic wNext(input logic w, input int a, input logic isA,
                                 input logic mt, input logic top);
    if (a == 0) return w;
    if (mode inside {0, 4, 12}) return !mt ? w : (a == 1) ? ~w : (a == 3);
    if (a == 1) return (mt && isA && mode >= 8) ? ~w : w;
    if (mode inside {[1:3], [8:11]}) return mt ? (countDown ^ (a == 3)) : w;
    if (top) return a == 2;
    return (mt && ceilOf(mode) != (isA ? cmpA : cmpB)) ? (a == 3) : w;
  endfunction : wNext
  // Whether the wave owns the pin
  function automatic logic conn(input int a, input logic isA);
    return a != 0 && !(a == 1 && !(mode inside {0, 4, 12}) && !(isA && mode >= 8));
  endfunction : conn
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk("regRdata", 16'(expQ.pop_front()), 16'(regRdata));
  endtask : rd
  // New compare A and capture values, then mode and actions; decode settles after
  task automatic setMode(input int m, input int a, input int b);
    @(posedge clock);
    rnd = lfsr(rnd);
    cmpA <= rnd[15:0] | 16'h0100;
    captureValue <= rnd[31:16] | 16'h0100;
    wr(2'h0, {2'(a), 2'(b), 2'b00, 2'(m)});
    wr(2'h1, {3'b000, 2'(m >> 2), 3'b000});
    mode = m;
    actA = a;
    actB = b;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : setMode
  // One counter cycle, then compare flops, pins and flag
  task automatic ev(input logic t, input logic mt, input logic [15:0] cnt, input logic dn);
    logic       ovf;
    logic [3:0] mA, mB;
    @(posedge clock);
    rnd = lfsr(rnd);
    tick <= t;
    matchA <= mt;
    matchB <= mt;
    countValue <= cnt;
    countDown <= dn;
    {portDirA, portDirB, portDataA, portDataB} <= rnd[15:0];
    @(negedge clock);
    ovf = t && cnt == (ovfOf(mode) == 0 ? 16'hFFFF : ovfOf(mode) == 1 ? ceilOf(mode) : 16'h0);
    if (t) begin
      wA = wNext(wA, actA, 1'b1, mt, cnt == ceilOf(mode));
      wB = wNext(wB, actB, 1'b0, mt, cnt == ceilOf(mode));
    end
    mA = conn(actA, 1'b1) ? pinEn[3:0] : 4'h0;
    mB = conn(actB, 1'b0) ? pinEn[7:4] : 4'h0;
    @(posedge clock);
    tick <= 1'b0;
    matchA <= 1'b0;
    matchB <= 1'b0;
    @(negedge clock);
    chk("overflowFlag", 16'(ovf), 16'(overflowFlag));
    chk("chanAWaveOut", 16'(wA), 16'(chanAWaveOut));
    chk("chanBWaveOut", 16'(wB), 16'(chanBWaveOut));
    chk("pinOutA", 16'((portDataA & ~mA) | ({4{wA}} & mA)), 16'(pinOutA));
    chk("pinOutB", 16'((portDataB & ~mB) | ({4{wB}} & mB)), 16'(pinOutB));
    chk("pinOeA", 16'(portDirA), 16'(pinOeA));
    chk("pinOeB", 16'(portDirB), 16'(pinOeB));
  endtask : ev
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the expected run
  initial begin
    #(25 * 4000);
    err_total++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("ceiling", 16'hFFFF, ceiling);
    for (int i = 0; i < 4; i++) rd(2'(i), 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'hF3);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h18);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'hA5);
    pinEn = 8'hA5;
    rd(2'h2, 8'hA5);
    // Every mode, reserved code too, with its overflow point
    for (int m = 0; m < 16; m++) begin
      setMode(m, 0, 0);
      chk("ceiling", ceilOf(m), ceiling);
      chk("ceilSource", 16'(srcOf(m)), 16'(ceilSource));
      chk("updatePoint", 16'(updOf(m)), 16'(updatePoint));
      chk("overflowPoint", 16'(ovfOf(m)), 16'(overflowPoint));
      chk("dualSlope", 16'(m inside {[1:3], [8:11]}), 16'(dualSlope));
      ev(1'b1, 1'b0, 16'h0005, 1'b0);
      ev(1'b1, 1'b0, ovfOf(m) == 0 ? 16'hFFFF : ovfOf(m) == 1 ? ceilOf(m) : 16'h0, 1'b0);
    end
    // Non-PWM actions, and a match without tick; then fast PWM clear/set in mode 5
    for (int i = 0; i < 4; i++) begin
      setMode(i == 1 ? 4 : i == 2 ? 12 : 0, i % 3 + 1, 3 - i % 3);
      ev(1'b1, 1'b1, 16'h0005, 1'b0);
      ev(1'b0, 1'b1, 16'h0005, 1'b0);
    end
    setMode(5, 2, 3);
    ev(1'b1, 1'b1, 16'h0010, 1'b0);
    ev(1'b1, 1'b0, 16'h00FF, 1'b0);
    ev(1'b1, 1'b1, 16'h00FF, 1'b0);
    // Compare A on the ceiling: its match away from the ceiling is dropped; then code 01 and dual-slope cases
    @(posedge clock);
    cmpA <= 16'h00FF;
    ev(1'b1, 1'b1, 16'h0010, 1'b0);
    setMode(5, 1, 1);
    ev(1'b1, 1'b1, 16'h0010, 1'b0);
    setMode(15, 1, 1);
    ev(1'b1, 1'b1, 16'h0010, 1'b0);
    setMode(1, 2, 3);
    ev(1'b1, 1'b1, 16'h0010, 1'b0);
    ev(1'b1, 1'b1, 16'h0010, 1'b1);
    rd(2'h3, {5'h00, countDown, wB, wA});
    end_sim();
  end
endmodule : twmoc_top_tb
`default_nettype wire
